/* File: rtl/drive_speed_monitor_config.sv */
// drive speed monitor config: mode decode, time selection, supervision
// assumes switch and terminal inputs are asynchronous to mclk; speeds
// come from drive logic on the same clock
`timescale 1ns/100ps
module drive_speed_monitor_config #(
    parameter int TICK_LEN = speed_monitor_pkg::TICK_CYCLES
) (
    input wire logic mclk, // 100 MHz clock
    input wire logic nrst, // async reset, active low
    input wire logic [3:0] busAddressSwitch, // bit0 low .. bit3 high
    input wire logic monitorSelectSwitch, // selector switch
    input wire logic extMonitorFunc, // extended monitoring selected
    input wire logic brakeFuncOther, // other brake functions selected
    input wire logic [3:0] rampTimeSelector, // ramp switch detent
    input wire logic [3:0] secondSetpointSelector, // second switch detent
    input wire logic setpointSelectInput, // setpoint select terminal
    input wire logic [6:0] firstSetpointPot, // potentiometer in Hz
    input wire logic [6:0] secondSetpointHz, // decoded second setpoint
    input wire logic [6:0] setpointHz, // active setpoint, drive clock
    input wire logic [6:0] actualHz, // actual speed, drive clock
    input wire logic brakeCmd, // brake release from drive logic
    input wire logic driveReady, // drive ready from drive logic
    output logic busMode_ff, // 1 serial bus, 0 binary
    output logic hoistActive_ff, // hoist behaviour on
    output logic supervisionOn_ff, // speed supervision enabled
    output logic [4:0] monTime1_ff, // time 1, 100 ms units
    output logic [4:0] monTime2_ff, // time 2, 100 ms units
    output logic [4:0] monTime3_ff, // time 3, 100 ms units
    output logic [3:0] rampSel_ff, // ramp detent, 0xF means fixed 1 s
    output logic [6:0] useSetpoint_ff, // setpoint in use, Hz
    output logic minFreqFixed_ff, // minimum frequency fixed
    output logic [6:0] minFreq_ff, // minimum frequency, Hz
    output logic brakeReadyRelay_ff, // relay contact
    output logic [1:0] phase_ff, // valid monitoring time index
    output logic monFault_ff // sticky speed monitoring fault
);
    // ==========================================================
    // input synchronisers
    // ==========================================================
    localparam int SW_W = 23;
    logic [SW_W-1:0] swRaw;
    logic [SW_W-1:0] s1_ff, s2_ff, s3_ff, swStable_ff;
    assign swRaw = {busAddressSwitch, monitorSelectSwitch, extMonitorFunc,
                    brakeFuncOther, rampTimeSelector,
                    secondSetpointSelector, setpointSelectInput,
                    firstSetpointPot};
    // a bit changes only when stages two and three agree
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            swStable_ff <= '0;
        end else begin
            s1_ff <= swRaw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (int i = 0; i < SW_W; i++) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    swStable_ff[i] <= s3_ff[i];
                end
            end
        end
    end
    logic [3:0] addr, rampDet, secDet;
    logic selOn, extOn, brkOther, selInput;
    logic [6:0] potHz;
    assign {addr, selOn, extOn, brkOther, rampDet, secDet, selInput,
            potHz} = swStable_ff;

    // detent to 100 ms ticks; out-of-range detents saturate to 1.5 s
    function automatic logic [4:0] detentTime(input logic [3:0] d);
        if (d < speed_monitor_pkg::DETENT_MAX) begin
            return {1'b0, d} + 5'h01;
        end
        return speed_monitor_pkg::DETENT10_TICKS;
    endfunction : detentTime

    // ==========================================================
    // configuration decode
    // ==========================================================
    logic nxt_busMode;
    assign nxt_busMode = (addr != 4'h0);
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busMode_ff <= 1'b0;
            hoistActive_ff <= 1'b0;
            supervisionOn_ff <= 1'b0;
            minFreqFixed_ff <= 1'b0;
            minFreq_ff <= 7'h00;
        end else begin
            busMode_ff <= nxt_busMode;
            hoistActive_ff <= extOn;
            // selector no longer gates supervision once extended is on
            supervisionOn_ff <= extOn | selOn;
            minFreqFixed_ff <= nxt_busMode;
            minFreq_ff <= nxt_busMode ? speed_monitor_pkg::MIN_FREQ_BUS_HZ
                                      : 7'h00;
        end
    end

    // monitoring time and ramp selection
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            monTime1_ff <= speed_monitor_pkg::MON_TIME_RST;
            monTime2_ff <= speed_monitor_pkg::MON_TIME_RST;
            monTime3_ff <= speed_monitor_pkg::MON_TIME_RST;
            rampSel_ff <= 4'hF;
        end else if (selOn) begin
            monTime2_ff <= detentTime(secDet);
            monTime1_ff <= speed_monitor_pkg::FIXED_TIME_TICKS;
            monTime3_ff <= speed_monitor_pkg::FIXED_TIME_TICKS;
            rampSel_ff <= rampDet;
        end else begin
            monTime2_ff <= detentTime(rampDet);
            rampSel_ff <= 4'hF;
            if (nxt_busMode) begin
                monTime1_ff <= detentTime(secDet);
                monTime3_ff <= detentTime(secDet);
            end else begin
                monTime1_ff <= speed_monitor_pkg::FIXED_TIME_TICKS;
                monTime3_ff <= speed_monitor_pkg::FIXED_TIME_TICKS;
            end
        end
    end

    // setpoint in use for binary control; zero under bus control
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            useSetpoint_ff <= speed_monitor_pkg::POT_FACTORY_HZ;
        end else if (nxt_busMode) begin
            useSetpoint_ff <= 7'h00;
        end else if (selOn) begin
            useSetpoint_ff <= speed_monitor_pkg::FIXED_SETPOINT_HZ;
        end else if (!selInput) begin
            useSetpoint_ff <= potHz;
        end else begin
            useSetpoint_ff <= secondSetpointHz;
        end
    end

    // relay: brake control when any brake function, else ready
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            brakeReadyRelay_ff <= 1'b0;
        end else if (extOn | brkOther) begin
            brakeReadyRelay_ff <= brakeCmd;
        end else begin
            brakeReadyRelay_ff <= driveReady;
        end
    end

    // ==========================================================
    // supervision phases and lag timer
    // ==========================================================
    speed_monitor_pkg::phase_type state_ff, nxt_phase;
    logic [6:0] prevSet_ff;
    // a lag inside hold keeps time 2; only a new setpoint reopens rise
    // or fall, so a stalled load is judged against the right time
    always_comb begin
        nxt_phase = state_ff;
        if (actualHz == setpointHz) begin
            if (setpointHz == 7'h00 &&
                state_ff == speed_monitor_pkg::PH_IDLE) begin
                nxt_phase = speed_monitor_pkg::PH_IDLE;
            end else begin
                nxt_phase = speed_monitor_pkg::PH_HOLD;
            end
        end else if (state_ff == speed_monitor_pkg::PH_HOLD &&
                     setpointHz == prevSet_ff) begin
            nxt_phase = speed_monitor_pkg::PH_HOLD;
        end else if (actualHz < setpointHz) begin
            nxt_phase = speed_monitor_pkg::PH_RISE;
        end else begin
            nxt_phase = speed_monitor_pkg::PH_FALL;
        end
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= speed_monitor_pkg::PH_IDLE;
            prevSet_ff <= 7'h00;
        end else begin
            state_ff <= nxt_phase;
            prevSet_ff <= setpointHz;
        end
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            phase_ff <= 2'h0;
        end else begin
            unique case (nxt_phase)
                speed_monitor_pkg::PH_IDLE: phase_ff <= 2'h0;
                speed_monitor_pkg::PH_RISE: phase_ff <= 2'h1;
                speed_monitor_pkg::PH_HOLD: phase_ff <= 2'h2;
                speed_monitor_pkg::PH_FALL: phase_ff <= 2'h3;
            endcase
        end
    end

    // lag timer: counts 100 ms ticks while speed is off setpoint
    logic [4:0] limit;
    logic [31:0] tickCnt_ff;
    logic [4:0] lagTicks_ff;
    logic lagging;
    assign lagging = (actualHz != setpointHz);
    always_comb begin
        unique case (state_ff)
            speed_monitor_pkg::PH_IDLE: limit = monTime2_ff;
            speed_monitor_pkg::PH_RISE: limit = monTime1_ff;
            speed_monitor_pkg::PH_HOLD: limit = monTime2_ff;
            speed_monitor_pkg::PH_FALL: limit = monTime3_ff;
        endcase
    end
    // timer restarts on phase change so each time is measured alone
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tickCnt_ff <= '0;
            lagTicks_ff <= 5'h00;
            monFault_ff <= 1'b0;
        end else begin
            if (!lagging || nxt_phase != state_ff || !supervisionOn_ff) begin
                tickCnt_ff <= '0;
                lagTicks_ff <= 5'h00;
            end else if (tickCnt_ff == 32'(TICK_LEN - 1)) begin
                tickCnt_ff <= '0;
                if (lagTicks_ff != 5'h1F) begin
                    lagTicks_ff <= lagTicks_ff + 5'h01;
                end
            end else begin
                tickCnt_ff <= tickCnt_ff + 32'h1;
            end
            if (supervisionOn_ff && lagging && lagTicks_ff >= limit) begin
                monFault_ff <= 1'b1;
            end
        end
    end

    // ==========================================================
    // assertions
    // ==========================================================
    bus_min_freq_a: assert property (
        @(posedge mclk) disable iff (!nrst)
        busMode_ff |-> minFreq_ff == speed_monitor_pkg::MIN_FREQ_BUS_HZ)
        else $error("bus mode minimum frequency wrong");
    addr_mode_a: assert property (
        @(posedge mclk) disable iff (!nrst)
        ##1 busMode_ff == ($past(addr) != 4'h0))
        else $error("mode does not follow address");
    ext_super_a: assert property (
        @(posedge mclk) disable iff (!nrst)
        extOn ##1 $past(extOn) |-> supervisionOn_ff && hoistActive_ff)
        else $error("extended monitoring not forcing supervision");
    sel_on_times_a: assert property (
        @(posedge mclk) disable iff (!nrst)
        selOn |=> monTime1_ff == speed_monitor_pkg::FIXED_TIME_TICKS &&
                  monTime3_ff == speed_monitor_pkg::FIXED_TIME_TICKS)
        else $error("selector on: times 1 and 3 not 1 s");
    bin_off_ramp_a: assert property (
        @(posedge mclk) disable iff (!nrst)
        !selOn && !nxt_busMode |=> rampSel_ff == 4'hF &&
            monTime1_ff == speed_monitor_pkg::FIXED_TIME_TICKS)
        else $error("binary selector off settings wrong");
    fixed_set_a: assert property (
        @(posedge mclk) disable iff (!nrst)
        selOn && !nxt_busMode |=>
            useSetpoint_ff == speed_monitor_pkg::FIXED_SETPOINT_HZ)
        else $error("fixed 5 Hz setpoint missing");
    detent_ten_a: assert property (
        @(posedge mclk) disable iff (!nrst)
        selOn && secDet == speed_monitor_pkg::DETENT_MAX |=>
            monTime2_ff == speed_monitor_pkg::DETENT10_TICKS)
        else $error("detent 10 not 1.5 s");
    relay_ready_a: assert property (
        @(posedge mclk) disable iff (!nrst)
        !extOn && !brkOther |=> brakeReadyRelay_ff == $past(driveReady))
        else $error("relay not showing ready");
endmodule : drive_speed_monitor_config

/* File: rtl/speed_monitor_pkg.sv */
// package: constants for the speed monitoring configuration block
// assumes a 100 MHz mclk; times are held in units of 100 ms
package speed_monitor_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_MS = 100;
    // cycles in one 100 ms tick, derived from the clock period
    localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [4:0] FIXED_TIME_TICKS = 5'h0A; // 1 s
    localparam logic [4:0] DETENT10_TICKS = 5'h0F; // 1.5 s
    localparam logic [3:0] DETENT_MAX = 4'hA;
    localparam logic [6:0] FIXED_SETPOINT_HZ = 7'h05;
    localparam logic [6:0] MIN_FREQ_BUS_HZ = 7'h02;
    localparam logic [6:0] POT_FACTORY_HZ = 7'h32; // 50 Hz, about 1500 rpm
    localparam logic [4:0] MON_TIME_RST = 5'h0A;
    // monitoring phases: which time is currently valid
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_RISE = 2'b01,
        PH_HOLD = 2'b11,
        PH_FALL = 2'b10
    } phase_type;
endpackage : speed_monitor_pkg

/* File: tb/drive_model.sv */
// drive model: the actual speed follows the setpoint one Hz per cycle
// assumes the bench drives the setpoint and the stall flag on mclk
`timescale 1ns/100ps
module drive_model (
    input wire logic mclk, // 100 MHz clock
    input wire logic nrst, // async reset, active low
    input wire logic [6:0] setpointHz, // commanded speed
    input wire logic stall, // jammed load, speed stops moving
    output logic [6:0] actualHz_ff // measured speed
);
    // ========================================
    // speed tracking
    // one step a cycle keeps rise and fall visible for many edges
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            actualHz_ff <= 7'h00;
        end else if (stall) begin
            actualHz_ff <= actualHz_ff;
        end else if (actualHz_ff < setpointHz) begin
            actualHz_ff <= actualHz_ff + 7'h01;
        end else if (actualHz_ff > setpointHz) begin
            actualHz_ff <= actualHz_ff - 7'h01;
        end
    end
endmodule : drive_model

/* File: tb/tb.sv */
// testbench: switch settings in, decoded configuration and phase out
// assumes drive_model supplies the actual speed; short tick of 4 cycles
`timescale 1ns/100ps
module tb;
    logic mclk = 1'b0, nrst = 1'b0, sel = 1'b0, ext = 1'b0, brk = 1'b0;
    logic fsel = 1'b0, brakeCmd = 1'b0, driveReady = 1'b0, stall = 1'b0;
    logic [3:0] addr = 4'h0, ramp = 4'h0, sec = 4'h0;
    logic [6:0] pot = 7'h2A, sec2Hz = 7'h19, setHz = 7'h00, actHz;
    logic busMode, hoist, superOn, minFix, relay, fault;
    logic [4:0] mt1, mt2, mt3;
    logic [3:0] rampSel;
    logic [6:0] useSp, minFreq;
    logic [1:0] phase;
    logic [3:0] addrList [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hF};
    int failCount = 0, totalChecks = 0;
    // ========================================
    // clock, design and partner
    always #5 mclk = ~mclk;
    drive_speed_monitor_config #(.TICK_LEN(4)) dut (.mclk(mclk),
        .nrst(nrst), .busAddressSwitch(addr), .monitorSelectSwitch(sel),
        .extMonitorFunc(ext), .brakeFuncOther(brk),
        .rampTimeSelector(ramp), .secondSetpointSelector(sec),
        .setpointSelectInput(fsel), .firstSetpointPot(pot),
        .secondSetpointHz(sec2Hz), .setpointHz(setHz), .actualHz(actHz),
        .brakeCmd(brakeCmd), .driveReady(driveReady), .busMode_ff(busMode),
        .hoistActive_ff(hoist), .supervisionOn_ff(superOn),
        .monTime1_ff(mt1), .monTime2_ff(mt2), .monTime3_ff(mt3),
        .rampSel_ff(rampSel), .useSetpoint_ff(useSp),
        .minFreqFixed_ff(minFix), .minFreq_ff(minFreq),
        .brakeReadyRelay_ff(relay), .phase_ff(phase), .monFault_ff(fault));
    drive_model partner (.mclk(mclk), .nrst(nrst), .setpointHz(setHz),
        .stall(stall), .actualHz_ff(actHz));
    // ========================================
    // shared tasks
    task automatic check(input logic [6:0] seen, input logic [6:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            failCount++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen,
                exp);
        end
    endtask : check
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : wt
    // switches go through a 3-flop filter, so allow 8 edges to settle
    task automatic set_sw(input logic [3:0] a, input logic s, e, b, f,
        input logic [3:0] r, q);
        @(posedge mclk);
        addr <= a;
        sel <= s;
        ext <= e;
        brk <= b;
        fsel <= f;
        ramp <= r;
        sec <= q;
        wt(8);
    endtask : set_sw
    // detent to 100 ms units; detent 10 and anything past it read as 1.5 s
    function automatic logic [6:0] tm(input logic [3:0] d);
        return (d <= 4'h9) ? 7'(d) + 7'h01 : 7'h0F;
    endfunction : tm
    task automatic give_verdict;
        if (failCount == 0 && totalChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    // ========================================
    // watchdog, far beyond the roughly 800 cycles the tests need
    initial begin
        wt(20000);
        failCount++;
        give_verdict();
    end
    // ========================================
    // test sequence
    initial begin
        wt(5);
        check(7'(mt1), 7'h0A);
        check(7'(rampSel), 7'h0F);
        check(useSp, 7'h32);
        wt(5);
        nrst <= 1'b1;
        // address zero against each single nonzero switch and all on
        foreach (addrList[i]) begin
            set_sw(addrList[i], 1'b0, 1'b1, 1'b0, 1'b0, 4'h3, 4'h4);
            check(7'(busMode), 7'(addrList[i] != 4'h0));
            check(minFreq, (addrList[i] != 4'h0) ? 7'h02 : 7'h00);
            check(7'(minFix), 7'(addrList[i] != 4'h0));
        end
        // detents 0 to 11 in every mode and selector position
        for (int d = 0; d < 12; d++) begin
            set_sw(4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 4'(d), 4'h0);
            check(7'(mt2), tm(4'(d)));
            check(7'(mt1), 7'h0A);
            check(7'(mt3), 7'h0A);
            check(7'(rampSel), 7'h0F);
            set_sw(4'h0, 1'b1, 1'b1, 1'b0, 1'b0, 4'h6, 4'(d));
            check(7'(mt2), tm(4'(d)));
            check(7'(mt1), 7'h0A);
            check(7'(mt3), 7'h0A);
            check(7'(rampSel), 7'h06);
            check(useSp, 7'h05);
            set_sw(4'h2, 1'b0, 1'b1, 1'b0, 1'b0, 4'(d), 4'(11 - d));
            check(7'(mt2), tm(4'(d)));
            check(7'(mt1), tm(4'(11 - d)));
            check(7'(mt3), tm(4'(11 - d)));
            check(7'(rampSel), 7'h0F);
            set_sw(4'h8, 1'b1, 1'b1, 1'b0, 1'b0, 4'h2, 4'(d));
            check(7'(mt2), tm(4'(d)));
            check(7'(mt1), 7'h0A);
            check(7'(mt3), 7'h0A);
            check(7'(rampSel), 7'h02);
            check(minFreq, 7'h02);
            check(useSp, 7'h00);
        end
        set_sw(4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h1, 4'h1);
        check(useSp, pot);
        set_sw(4'h0, 1'b0, 1'b1, 1'b0, 1'b1, 4'h1, 4'h1);
        check(useSp, sec2Hz);
        // extended, selector and other brake functions in all pairings
        for (int k = 0; k < 8; k++) begin
            set_sw(4'h0, k[0], k[1], k[2], 1'b0, 4'h1, 4'h1);
            driveReady <= 1'b1;
            brakeCmd <= 1'b0;
            wt(3);
            check(7'(hoist), 7'(k[1]));
            check(7'(superOn), 7'(k[1] | k[0]));
            check(7'(relay), 7'(!(k[1] | k[2])));
            driveReady <= 1'b0;
            brakeCmd <= 1'b1;
            wt(3);
            check(7'(relay), 7'(k[1] | k[2]));
        end
        // supervision: times 1 and 3 are 1 s, i.e. 40 cycles here
        set_sw(4'h0, 1'b1, 1'b1, 1'b0, 1'b0, 4'h1, 4'h9);
        setHz <= 7'h14;
        wt(3);
        check(7'(phase), 7'h01);
        wt(27);
        check(7'(phase), 7'h02);
        setHz <= 7'h05;
        wt(3);
        check(7'(phase), 7'h03);
        wt(27);
        check(7'(fault), 7'h00);
        stall <= 1'b1;
        setHz <= 7'h1E;
        wt(30);
        check(7'(fault), 7'h00);
        wt(20);
        check(7'(fault), 7'h01);
        stall <= 1'b0;
        wt(40);
        check(7'(fault), 7'h01);
        // a second reset is the only way to clear the sticky fault
        nrst <= 1'b0;
        wt(2);
        check(7'(fault), 7'h00);
        @(posedge mclk);
        nrst <= 1'b1;
        wt(8);
        check(7'(superOn), 7'h01);
        check(7'(fault), 7'h00);
        give_verdict();
    end
endmodule : tb
